// ==== design/chol_pkg.sv ====
package chol_pkg;

    // Clock and timing
    localparam int          CLK_MHZ            = 50;
    localparam int          US_PER_MS          = 1000;
    localparam longint      SEC_PER_HOUR       = 3600;
    localparam longint      US_PER_SEC         = 1000000;
    localparam int          STRAP_SETTLE_US    = 40;
    localparam int          STRAP_SETTLE_CYC   = STRAP_SETTLE_US * CLK_MHZ;
    localparam int          ENTRY_DEBOUNCE_US  = 1000;
    localparam int          ENTRY_DEBOUNCE_CYC = ENTRY_DEBOUNCE_US * CLK_MHZ;
    localparam int          TERM_SHORT_MS      = 20;
    localparam int          TERM_SHORT_CYC     = TERM_SHORT_MS * US_PER_MS * CLK_MHZ;
    localparam int          TERM_LONG_MS       = 200;
    localparam int          TERM_LONG_CYC      = TERM_LONG_MS * US_PER_MS * CLK_MHZ;
    localparam longint      AC_LIMIT_HOURS     = 12;
    localparam longint      AC_LIMIT_CYC       = AC_LIMIT_HOURS * SEC_PER_HOUR * US_PER_SEC
                                                 * longint'(CLK_MHZ);

    // Widths
    localparam int          DW      = 16;
    localparam int          AW      = 8;
    localparam int          TMR_W   = 42;
    localparam int          DBT_W   = 24;
    localparam int          SET_W   = 11;
    localparam int          BAND_W  = 5;

    // Register offsets
    localparam logic [7:0]  ADDR_CTRL1  = 8'h00;
    localparam logic [7:0]  ADDR_CTRL3  = 8'h01;
    localparam logic [7:0]  ADDR_ALIM1  = 8'h02;
    localparam logic [7:0]  ADDR_ALIM2  = 8'h03;
    localparam logic [7:0]  ADDR_VMAX   = 8'h04;
    localparam logic [7:0]  ADDR_VMIN   = 8'h05;
    localparam logic [7:0]  ADDR_ICHG   = 8'h06;
    localparam logic [7:0]  ADDR_STATUS = 8'h07;

    // Field positions
    localparam int          C1_SYSTEM_POWER_MONITOR_BIT = 3;
    localparam int          C1_FREQ_LSB = 8;
    localparam int          C3_AUTO_BIT = 7;
    localparam int          C3_SHIP_BIT = 10;
    localparam int          C3_TERM_BIT = 13;

    // Reset values and encodings, currents at 4 mA per LSB except TERM_MA in mA
    localparam logic [15:0] CTRL_RST     = 16'h0000;
    localparam logic [15:0] ICHG_RST     = 16'h0000;
    localparam logic [15:0] ALIM_0P476   = 16'h0077;
    localparam logic [15:0] ALIM_1P5     = 16'h0177;
    localparam logic [15:0] AC_CHARGE_2A = 16'h01f4;
    localparam logic [15:0] TERM_MA      = 16'h00c8;
    localparam logic [15:0] RECHG_MV     = 16'h00c8;
    localparam logic [1:0]  FREQ_733K    = 2'h0;
    localparam logic [1:0]  FREQ_1M      = 2'h1;
    localparam logic [4:0]  BAND_LAST    = 5'h18;
    localparam logic [3:0]  BAND_GROUP   = 4'hc;

    // Voltage defaults per cell count in mV, indexed by cells minus one
    localparam logic [15:0] VMAX_DEF [4] = '{16'h1068, 16'h20d0, 16'h3138, 16'h41a0};
    localparam logic [15:0] VMIN_DEF [4] = '{16'h0c00, 16'h1800, 16'h2400, 16'h3000};

    typedef struct packed {
        logic [1:0]  cells;
        logic [1:0]  freq;
        logic        auto_en;
        logic [15:0] alim;
    } chol_strap_type;

    typedef enum logic [1:0] {AC_OFF, AC_WAIT, AC_CHARGE, AC_HALT} chol_ac_type;

    // Bands repeat every twelve entries; the last band is a one-cell option
    function automatic chol_strap_type chol_decode(input logic [4:0] band);
        chol_strap_type r;
        logic [3:0]     m;
        m         = 4'(band % 5'(BAND_GROUP));
        r.cells   = (band >= BAND_LAST) ? 2'h0 : 2'(band / 5'h6);
        r.freq    = (m == 4'h2 || m == 4'h3 || m == 4'h8 || m == 4'h9) ? FREQ_1M : FREQ_733K;
        r.auto_en = (m >= 4'h4) && (m <= 4'h7);
        r.alim    = (m == 4'h1 || m == 4'h2 || m == 4'h5 || m == 4'h6 || m == 4'h9
                     || m == 4'ha) ? ALIM_1P5 : ALIM_0P476;
        if (band >= BAND_LAST) begin
            r.freq    = FREQ_733K;
            r.auto_en = 1'b0;
            r.alim    = ALIM_0P476;
        end
        return r;
    endfunction

endpackage

// ==== design/chol_loader.sv ====
`timescale 1ns/10ps
module chol_loader #(
    parameter logic [23:0] DEBOUNCE_CYC   = 24'(chol_pkg::ENTRY_DEBOUNCE_CYC),
    parameter logic [23:0] TERM_SHORT_CYC = 24'(chol_pkg::TERM_SHORT_CYC),
    parameter logic [23:0] TERM_LONG_CYC  = 24'(chol_pkg::TERM_LONG_CYC),
    parameter logic [41:0] AC_LIMIT_CYC   = 42'(chol_pkg::AC_LIMIT_CYC)
) (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    // Register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [15:0] reg_rdata_o,
    // Pins and converters
    input  wire logic        adapter_present_i,
    input  wire logic        cv_loop_i,
    input  wire logic [4:0]  strap_band_i,
    input  wire logic [15:0] batt_mv_i,
    input  wire logic [15:0] charge_ma_i,
    // Strap source and switch gates
    output logic             strap_source_en_o,
    output logic             adapter_switch_gate_o,
    output logic             battery_switch_gate_o,
    // Hot alert open-drain pin
    output logic             hot_alert_o,
    output logic             hot_alert_oe_o,
    // Settings to the regulator
    output logic [1:0]       cell_count_o,
    output logic [1:0]       freq_sel_o,
    output logic [15:0]      adapter_limit_primary_o,
    output logic [15:0]      adapter_limit_secondary_o,
    output logic [15:0]      upper_system_voltage_o,
    output logic [15:0]      lower_system_voltage_o,
    output logic [15:0]      charge_current_cmd_o,
    output logic             charge_timeout_en_o,
    output logic             charging_o
);

    typedef struct packed {
        logic                 adp_m;
        logic                 adp_s;
        logic                 adp_d;
        logic                 cv_m;
        logic                 cv_s;
        logic                 reading;
        logic                 read_done;
        logic                 pend_full;
        logic                 pend_ins;
        logic [10:0]          settle;
        chol_pkg::chol_strap_type code;
        logic [15:0]          ctrl1;
        logic [15:0]          ctrl3;
        logic [15:0]          alim1;
        logic [15:0]          alim2;
        logic [15:0]          vmax;
        logic [15:0]          vmin;
        logic [15:0]          ichg;
        chol_pkg::chol_ac_type ac_st;
        logic [23:0]          dbt;
        logic [41:0]          tmr;
        logic                 agate;
        logic                 battery_switch_gate;
        logic                 charging;
        logic [15:0]          chg_cmd;
        logic [15:0]          rdata;
    } chol_state_type;

    chol_state_type st_ff;
    chol_state_type nxt_st;

    logic        adp_rise;
    logic        wr_ctrl1;
    logic        system_power_monitor_rise;
    logic        settle_end;
    logic        below_thr;
    logic        at_term;
    logic [15:0] margin;
    logic [23:0] term_cyc;

    // Address match shared by the write and read paths
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // Read mux; unmapped offsets read as zero
    function automatic logic [15:0] reg_read(input logic [7:0] a, input chol_state_type s);
        logic [15:0] r;
        r = 16'h0000;
        if (hit(a, chol_pkg::ADDR_CTRL1)) r = s.ctrl1;
        if (hit(a, chol_pkg::ADDR_CTRL3)) r = s.ctrl3;
        if (hit(a, chol_pkg::ADDR_ALIM1)) r = s.alim1;
        if (hit(a, chol_pkg::ADDR_ALIM2)) r = s.alim2;
        if (hit(a, chol_pkg::ADDR_VMAX)) r = s.vmax;
        if (hit(a, chol_pkg::ADDR_VMIN)) r = s.vmin;
        if (hit(a, chol_pkg::ADDR_ICHG)) r = s.ichg;
        if (hit(a, chol_pkg::ADDR_STATUS)) begin
            r = {3'h0, s.code.cells, s.ac_st, s.charging, s.agate, s.battery_switch_gate,
                 s.reading, s.read_done, s.pend_full, s.pend_ins, 2'h0};
        end
        return r;
    endfunction

    // Event decode from the synchronised adapter level, the host write and the settle counter
    assign adp_rise   = st_ff.adp_s & ~st_ff.adp_d;
    assign wr_ctrl1   = reg_wr_i & hit(reg_addr_i, chol_pkg::ADDR_CTRL1);
    assign system_power_monitor_rise  = wr_ctrl1 & reg_wdata_i[chol_pkg::C1_SYSTEM_POWER_MONITOR_BIT]
                        & ~st_ff.ctrl1[chol_pkg::C1_SYSTEM_POWER_MONITOR_BIT];
    assign settle_end = st_ff.reading & (st_ff.settle == 11'(chol_pkg::STRAP_SETTLE_CYC - 1));
    // Threshold is 200 mV per cell below the upper system voltage
    assign margin     = 16'(({14'h0, st_ff.code.cells} + 16'h0001) * chol_pkg::RECHG_MV);
    assign below_thr  = batt_mv_i < (st_ff.vmax - margin);
    assign at_term    = st_ff.cv_s & (charge_ma_i < chol_pkg::TERM_MA);
    assign term_cyc   = st_ff.ctrl3[chol_pkg::C3_TERM_BIT] ? TERM_LONG_CYC : TERM_SHORT_CYC;

    // Next-state logic for the whole block
    always_comb begin
        nxt_st       = st_ff;
        // Two-flop synchronisers; the first stage feeds only the second
        nxt_st.adp_m = adapter_present_i;
        nxt_st.adp_s = st_ff.adp_m;
        nxt_st.adp_d = st_ff.adp_s;
        nxt_st.cv_m  = cv_loop_i;
        nxt_st.cv_s  = st_ff.cv_m;

        // Host writes
        if (reg_wr_i) begin
            if (wr_ctrl1) begin
                nxt_st.ctrl1 = reg_wdata_i;
            end
            if (hit(reg_addr_i, chol_pkg::ADDR_CTRL3)) begin
                nxt_st.ctrl3 = reg_wdata_i;
            end
            if (hit(reg_addr_i, chol_pkg::ADDR_ALIM1)) begin
                nxt_st.alim1 = reg_wdata_i;
            end
            if (hit(reg_addr_i, chol_pkg::ADDR_ALIM2)) begin
                nxt_st.alim2 = reg_wdata_i;
            end
            if (hit(reg_addr_i, chol_pkg::ADDR_VMIN)) begin
                nxt_st.vmin = reg_wdata_i;
            end
            if (hit(reg_addr_i, chol_pkg::ADDR_VMAX) || hit(reg_addr_i, chol_pkg::ADDR_ICHG)) begin
                nxt_st.ctrl3[chol_pkg::C3_AUTO_BIT] = 1'b0;
                if (hit(reg_addr_i, chol_pkg::ADDR_VMAX)) begin
                    nxt_st.vmax = reg_wdata_i;
                end else begin
                    nxt_st.ichg = reg_wdata_i;
                end
            end
        end

        // Settling wait, then latch the band; the code holds until the next read
        if (st_ff.reading && !settle_end) begin
            nxt_st.settle = st_ff.settle + 11'h001;
        end
        if (settle_end) begin
            nxt_st.code      = chol_pkg::chol_decode(strap_band_i);
            nxt_st.read_done = 1'b1;
            nxt_st.reading   = 1'b0;
            nxt_st.pend_full = 1'b0;
            nxt_st.pend_ins  = 1'b0;
            nxt_st.alim1     = nxt_st.code.alim;
            if (st_ff.pend_full) begin
                nxt_st.ctrl1[chol_pkg::C1_FREQ_LSB +: 2] = nxt_st.code.freq;
                nxt_st.ctrl3[chol_pkg::C3_AUTO_BIT]      = nxt_st.code.auto_en;
                nxt_st.alim2 = chol_pkg::ALIM_1P5;
            end
            if (st_ff.pend_ins && !st_ff.read_done) begin
                nxt_st.ctrl1[chol_pkg::C1_FREQ_LSB +: 2] = nxt_st.code.freq;
                nxt_st.ctrl3[chol_pkg::C3_AUTO_BIT]      = nxt_st.code.auto_en;
            end
            if (st_ff.pend_full || !nxt_st.ctrl1[chol_pkg::C1_SYSTEM_POWER_MONITOR_BIT]) begin
                nxt_st.vmax = chol_pkg::VMAX_DEF[nxt_st.code.cells];
                nxt_st.vmin = chol_pkg::VMIN_DEF[nxt_st.code.cells];
            end
        end

        // Strap read requests come after the apply, so a trigger in the last
        // settle cycle starts a fresh read instead of being lost
        if (system_power_monitor_rise && !st_ff.adp_s) begin
            nxt_st.pend_full = 1'b1;
            nxt_st.reading   = 1'b1;
            nxt_st.settle    = '0;
        end
        if (adp_rise) begin
            if (st_ff.read_done && !st_ff.reading) begin
                nxt_st.alim1 = st_ff.code.alim;
                if (!st_ff.ctrl1[chol_pkg::C1_SYSTEM_POWER_MONITOR_BIT]) begin
                    nxt_st.vmax = chol_pkg::VMAX_DEF[st_ff.code.cells];
                    nxt_st.vmin = chol_pkg::VMIN_DEF[st_ff.code.cells];
                end
            end else begin
                nxt_st.pend_ins = 1'b1;
                nxt_st.reading  = 1'b1;
                nxt_st.settle   = '0;
            end
        end

        // Adapter gate only closes once a strap reading exists
        nxt_st.agate = st_ff.adp_s & nxt_st.read_done & ~nxt_st.reading;
        nxt_st.battery_switch_gate = ~nxt_st.ctrl3[chol_pkg::C3_SHIP_BIT];

        // Autonomous charging; leaving the mode is forced by disable or adapter loss
        case (st_ff.ac_st)
            chol_pkg::AC_OFF: begin
                nxt_st.dbt = '0;
                if (st_ff.ctrl3[chol_pkg::C3_AUTO_BIT] && st_ff.adp_s) begin
                    nxt_st.ac_st = chol_pkg::AC_WAIT;
                end
            end
            chol_pkg::AC_WAIT: begin
                if (below_thr && st_ff.battery_switch_gate) begin
                    nxt_st.dbt = st_ff.dbt + 24'h000001;
                    if (st_ff.dbt == DEBOUNCE_CYC - 24'h000001) begin
                        nxt_st.ac_st = chol_pkg::AC_CHARGE;
                        nxt_st.dbt   = '0;
                        nxt_st.tmr   = '0;
                    end
                end else begin
                    nxt_st.dbt = '0;
                end
            end
            chol_pkg::AC_CHARGE: begin
                nxt_st.tmr = st_ff.tmr + 42'h1;
                nxt_st.dbt = at_term ? st_ff.dbt + 24'h000001 : '0;
                if (at_term && st_ff.dbt == term_cyc - 24'h000001) begin
                    nxt_st.ac_st = chol_pkg::AC_WAIT;
                    nxt_st.dbt   = '0;
                end else if (st_ff.tmr == AC_LIMIT_CYC - 42'h1) begin
                    nxt_st.ac_st = chol_pkg::AC_HALT;
                end
            end
            chol_pkg::AC_HALT: begin
                nxt_st.dbt = '0;
            end
            default: begin
                nxt_st.ac_st = chol_pkg::AC_OFF;
            end
        endcase
        if (!nxt_st.ctrl3[chol_pkg::C3_AUTO_BIT] || !st_ff.adp_s) begin
            nxt_st.ac_st = chol_pkg::AC_OFF;
        end

        // Registered outputs of the mode
        nxt_st.charging = nxt_st.ac_st == chol_pkg::AC_CHARGE;
        nxt_st.chg_cmd  = nxt_st.charging ? chol_pkg::AC_CHARGE_2A : nxt_st.ichg;

        // Read data stands only in the cycle after the strobe
        nxt_st.rdata = reg_rd_i ? reg_read(reg_addr_i, st_ff) : 16'h0000;
    end

    // State register with synchronous reset
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            st_ff       <= '0;
            st_ff.ctrl1 <= chol_pkg::CTRL_RST;
            st_ff.ctrl3 <= chol_pkg::CTRL_RST;
            st_ff.alim1 <= chol_pkg::ALIM_0P476;
            st_ff.alim2 <= chol_pkg::ALIM_1P5;
            st_ff.vmax  <= chol_pkg::VMAX_DEF[0];
            st_ff.vmin  <= chol_pkg::VMIN_DEF[0];
            st_ff.ichg  <= chol_pkg::ICHG_RST;
            st_ff.ac_st <= chol_pkg::AC_OFF;
            st_ff.battery_switch_gate <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs from the state flops; hot_alert_o is tied low and charge_timeout_en_o is the inverted charging flop
    assign reg_rdata_o               = st_ff.rdata;
    assign strap_source_en_o         = st_ff.reading;
    assign adapter_switch_gate_o     = st_ff.agate;
    assign battery_switch_gate_o     = st_ff.battery_switch_gate;
    assign hot_alert_o               = 1'b0;
    assign hot_alert_oe_o            = st_ff.charging;
    assign cell_count_o              = st_ff.code.cells;
    assign freq_sel_o                = st_ff.ctrl1[chol_pkg::C1_FREQ_LSB +: 2];
    assign adapter_limit_primary_o   = st_ff.alim1;
    assign adapter_limit_secondary_o = st_ff.alim2;
    assign upper_system_voltage_o    = st_ff.vmax;
    assign lower_system_voltage_o    = st_ff.vmin;
    assign charge_current_cmd_o      = st_ff.chg_cmd;
    assign charge_timeout_en_o       = ~st_ff.charging;
    assign charging_o                = st_ff.charging;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_host_term_write;
        reg_wr_i && (hit(reg_addr_i, chol_pkg::ADDR_ICHG) || hit(reg_addr_i, chol_pkg::ADDR_VMAX));
    endsequence

    sequence s_strap_start;
        $rose(strap_source_en_o);
    endsequence

    a_ship_gate_off: assert property (
        st_ff.ctrl3[chol_pkg::C3_SHIP_BIT] |-> !battery_switch_gate_o)
        else $error("Battery switch on in ship mode");

    a_mode_outputs: assert property (
        charging_o |-> hot_alert_oe_o && !hot_alert_o && !charge_timeout_en_o
                       && charge_current_cmd_o == chol_pkg::AC_CHARGE_2A)
        else $error("Autocharge outputs wrong");

    a_write_kills_auto: assert property (
        s_host_term_write |=> !st_ff.ctrl3[chol_pkg::C3_AUTO_BIT] ##1 !charging_o)
        else $error("Autocharge survived host write");

    a_gate_after_read: assert property (
        $rose(adapter_switch_gate_o) |-> st_ff.read_done && !strap_source_en_o)
        else $error("Adapter gate before strap read");

    a_strap_settles: assert property (
        s_strap_start |-> strap_source_en_o [*8])
        else $error("Strap sampled before settling");

    a_secondary_reset: assert property (
        $fell(reset_i) |-> adapter_limit_secondary_o == chol_pkg::ALIM_1P5)
        else $error("Secondary limit reset value wrong");

    a_auto_write_taken: assert property (
        reg_wr_i && hit(reg_addr_i, chol_pkg::ADDR_CTRL3) && !settle_end
        |=> st_ff.ctrl3[chol_pkg::C3_AUTO_BIT] == $past(reg_wdata_i[chol_pkg::C3_AUTO_BIT]))
        else $error("Autocharge enable write lost");

    a_entry_needs_gate: assert property (
        $rose(charging_o) |-> $past(battery_switch_gate_o) && $past(below_thr))
        else $error("Autocharge entered without gate or low battery");

    a_limit_bound: assert property (
        charging_o |-> st_ff.tmr < AC_LIMIT_CYC)
        else $error("Autocharge exceeded time limit");

endmodule

// ==== bench/chol_strap_model.sv ====
`timescale 1ns/10ps
// Strap resistor as seen through the band converter
module chol_strap_model (
    // Clock, source enable and band select
    input  wire logic       core_clk_i,
    input  wire logic       source_en_i,
    input  wire logic [4:0] band_i,
    // Converter output
    output logic      [4:0] band_o
);
    logic [4:0] band_ff = 5'h00;
    // No source current means no valid reading, so the code keeps moving
    always @(posedge core_clk_i) begin
        band_ff <= source_en_i ? band_i : ~band_ff;
    end
    assign band_o = band_ff;
endmodule

// ==== bench/test_charger_option_loader_autocharge.sv ====
`timescale 1ns/10ps
module test_charger_option_loader_autocharge;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        adp = 1'b0;
    logic        cv = 1'b0;
    logic [4:0]  bsel = 5'h00;
    logic [4:0]  band;
    logic [15:0] batt = 16'hffff;
    logic [15:0] ima = 16'h03e8;
    logic [15:0] rdata, alim1, alim2, vmax, vmin, cmd;
    logic [1:0]  cells, freq;
    logic        src, agate, battery_switch_gate, hot, hot_oe, tmo, chg;
    logic        rd_q = 1'b0;
    logic [15:0] expq[$];
    int          fails = 0;
    int          n_compared = 0;
    int          k, b, m, off, ec, ef, ea, eu;

    chol_strap_model i_strap (.core_clk_i(clk), .source_en_i(src), .band_i(bsel), .band_o(band));

    chol_loader #(.DEBOUNCE_CYC(24'h000014), .TERM_SHORT_CYC(24'h00000a),
                  .TERM_LONG_CYC(24'h00001e), .AC_LIMIT_CYC(42'h0c8)) i_dut (
        .core_clk_i(clk), .reset_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .adapter_present_i(adp),
        .cv_loop_i(cv), .strap_band_i(band), .batt_mv_i(batt), .charge_ma_i(ima),
        .strap_source_en_o(src), .adapter_switch_gate_o(agate),
        .battery_switch_gate_o(battery_switch_gate), .hot_alert_o(hot), .hot_alert_oe_o(hot_oe),
        .cell_count_o(cells), .freq_sel_o(freq), .adapter_limit_primary_o(alim1),
        .adapter_limit_secondary_o(alim2), .upper_system_voltage_o(vmax),
        .lower_system_voltage_o(vmin), .charge_current_cmd_o(cmd),
        .charge_timeout_en_o(tmo), .charging_o(chg));

    // Clock
    always #10 clk = ~clk;

    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task check(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // The expectation is queued when the strobe goes out
    task rd_reg(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        expq.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask

    function logic pick(input int s);
        case (s)
            0: return src;
            1: return agate;
            default: return chg;
        endcase
    endfunction

    // Bounded wait for an output level; running out ends the run
    task wait_lvl(input int s, input logic l, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(negedge clk);
            if (pick(s) === l) return;
        end
        fails++;
        $display("unexpected wait %0d expected %b seen %b", s, l, pick(s));
        end_sim();
    endtask

    // Read data stand only in the cycle after the strobe, so look mid-cycle
    always @(posedge clk) rd_q <= rd;
    always @(negedge clk) begin
        if (rd_q) begin
            if (expq.size() == 0) check("queue", 16'h0001, 16'h0000);
            else check("reg_rdata_o", expq.pop_front(), rdata);
        end
    end

    // Main sequence
    initial begin
        void'($urandom(32'h3719b221));
        off = $urandom % 25;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd_reg(chol_pkg::ADDR_VMAX, 16'd4200);
        rd_reg(chol_pkg::ADDR_VMIN, 16'd3072);
        rd_reg(chol_pkg::ADDR_ALIM2, 16'd375);
        repeat (50) @(negedge clk);
        check("strap_source_en_o", 16'h0000, {15'h0, src});
        // Every band, each one read afresh by a monitor enable on battery
        for (k = 0; k < 25; k++) begin
            b = (k + off) % 25;
            m = b % 12;
            ec = (b >= 24) ? 0 : b / 6;
            ef = (b < 24 && (m == 2 || m == 3 || m == 8 || m == 9)) ? 1 : 0;
            ea = (b < 24 && (m == 1 || m == 2 || m == 5 || m == 6 || m == 9 || m == 10))
                 ? 375 : 119;
            eu = (b < 24 && m >= 4 && m <= 7) ? 1 : 0;
            @(posedge clk);
            bsel <= 5'(b);
            wr_reg(chol_pkg::ADDR_ALIM2, 16'h0001);
            wr_reg(chol_pkg::ADDR_CTRL1, 16'h0000);
            wr_reg(chol_pkg::ADDR_CTRL1, 16'h0008);
            wait_lvl(0, 1'b1, 4);
            wait_lvl(0, 1'b0, 2100);
            check("cell_count_o", 16'(ec), {14'h0, cells});
            check("adapter_limit_primary_o", 16'(ea), alim1);
            check("adapter_limit_secondary_o", 16'd375, alim2);
            check("upper_system_voltage_o", 16'(4200 * (ec + 1)), vmax);
            check("lower_system_voltage_o", 16'(3072 * (ec + 1)), vmin);
            rd_reg(chol_pkg::ADDR_ALIM1, 16'(ea));
            rd_reg(chol_pkg::ADDR_ALIM2, 16'd375);
            rd_reg(chol_pkg::ADDR_VMAX, 16'(4200 * (ec + 1)));
            rd_reg(chol_pkg::ADDR_CTRL3, 16'(eu << 7));
            rd_reg(chol_pkg::ADDR_CTRL1, 16'(8 + (ef << 8)));
        end
        wr_reg(chol_pkg::ADDR_CTRL1, 16'h0100);
        @(negedge clk);
        check("freq_sel_o", 16'h0001, {14'h0, freq});
        wr_reg(chol_pkg::ADDR_VMAX, 16'h1234);
        adp <= 1'b1;
        wait_lvl(1, 1'b1, 20);
        rd_reg(chol_pkg::ADDR_VMAX, 16'(4200 * (ec + 1)));
        rd_reg(chol_pkg::ADDR_ALIM1, 16'(ea));
        wr_reg(chol_pkg::ADDR_CTRL3, 16'h0400);
        @(negedge clk);
        check("battery_switch_gate_o", 16'h0000, {15'h0, battery_switch_gate});
        wr_reg(chol_pkg::ADDR_CTRL3, 16'h0000);
        batt <= 16'($urandom % 1000);
        wr_reg(chol_pkg::ADDR_CTRL3, 16'h0080);
        wait_lvl(2, 1'b1, 40);
        check("hot_alert_oe_o", 16'h0001, {15'h0, hot_oe});
        check("hot_alert_o", 16'h0000, {15'h0, hot});
        check("charge_timeout_en_o", 16'h0000, {15'h0, tmo});
        check("charge_current_cmd_o", 16'(2000 / 4), cmd);
        // Status while charging: both gates on, a stored reading, no read running
        rd_reg(chol_pkg::ADDR_STATUS, 16'(16'h05d0 + (ec << 11)));
        @(posedge clk);
        cv <= 1'b1;
        ima <= 16'd100;
        wait_lvl(2, 1'b0, 20);
        @(posedge clk);
        cv <= 1'b0;
        ima <= 16'd1000;
        wait_lvl(2, 1'b1, 40);
        wr_reg(chol_pkg::ADDR_ICHG, 16'h0064);
        wait_lvl(2, 1'b0, 3);
        rd_reg(chol_pkg::ADDR_CTRL3, 16'h0000);
        wr_reg(chol_pkg::ADDR_CTRL3, 16'h2080);
        wait_lvl(2, 1'b1, 40);
        repeat (150) @(negedge clk);
        check("charging_o", 16'h0001, {15'h0, chg});
        wait_lvl(2, 1'b0, 110);
        // Monitor on with the adapter in: the next insertion keeps the voltages
        wr_reg(chol_pkg::ADDR_CTRL1, 16'h0108);
        wr_reg(chol_pkg::ADDR_VMAX, 16'h1234);
        adp <= 1'b0;
        wait_lvl(1, 1'b0, 10);
        @(posedge clk);
        adp <= 1'b1;
        wait_lvl(1, 1'b1, 20);
        rd_reg(chol_pkg::ADDR_VMAX, 16'h1234);
        rd_reg(chol_pkg::ADDR_ALIM1, 16'(ea));
        repeat (3) @(posedge clk);
        end_sim();
    end
endmodule
